// ===== rtl/timer_input_pkg.sv
// Package with register map, field layouts and enumerations of the timer input block
package timer_input_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL     = 8'h00;
   localparam logic [7:0] OFF_PRESCALE = 8'h04;
   localparam logic [7:0] OFF_EDGE     = 8'h08;
   localparam logic [7:0] OFF_STATUS   = 8'h0c;
   localparam logic [7:0] OFF_COUNT    = 8'h10;
   localparam logic [7:0] OFF_CAP_A    = 8'h14;
   localparam logic [7:0] OFF_CAP_B    = 8'h18;

   ////////////////////////////////////////////////////////////////////////////
   // Widths and prescaler taps
   localparam int COUNT_W      = 16;
   localparam int PRESC_W      = 8;
   localparam int PRE_SHIFT_LO  = 1;
   localparam int PRE_SHIFT_MID = 3;
   localparam int PRE_SHIFT_HI  = 6;

   ////////////////////////////////////////////////////////////////////////////
   // Enumerations
   typedef enum logic [1:0] {
      EDGE_FALL = 2'h0,
      EDGE_RISE = 2'h1,
      EDGE_BOTH = 2'h2,
      EDGE_NONE = 2'h3
   } edge_sel_t;

   typedef enum logic [1:0] {
      CLK_DIV_LO  = 2'h0,
      CLK_DIV_MID = 2'h1,
      CLK_DIV_HI  = 2'h2,
      CLK_EDGE_A  = 2'h3
   } clk_sel_t;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_DATA = 2'b10
   } bus_state_t;

   ////////////////////////////////////////////////////////////////////////////
   // Register field layouts (bit 0 is the last member)
   typedef struct packed {
      logic out_level;
      logic pin_is_output;
      logic cap_b_en;
      logic cap_a_en;
      logic run;
   } ctrl_t;

   typedef struct packed {
      edge_sel_t b;
      edge_sel_t a;
   } edge_cfg_t;

   typedef struct packed {
      logic level_b;
      logic level_a;
      logic ovr_b;
      logic ovr_a;
      logic cap_b;
      logic cap_a;
   } status_t;

   localparam int CTRL_W   = $bits(ctrl_t);
   localparam int EDGE_W   = $bits(edge_cfg_t);
   localparam int STATUS_W = $bits(status_t);
   localparam int FLAG_W   = 4;
   localparam int PSEL_W   = $bits(clk_sel_t);

   ////////////////////////////////////////////////////////////////////////////
   // Status bit positions for write-one clear
   localparam int STS_CAP_A = 0;
   localparam int STS_CAP_B = 1;
   localparam int STS_OVR_A = 2;
   localparam int STS_OVR_B = 3;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam ctrl_t     CTRL_RST     = ctrl_t'(5'h00);
   localparam clk_sel_t  PRESCALE_RST = CLK_DIV_LO;
   localparam edge_cfg_t EDGE_RST     = edge_cfg_t'(4'h0);

endpackage

// ===== rtl/timer_prescaler.sv
// Free running prescaler giving one-cycle count clock enables
`timescale 1ns/1ps
module timer_prescaler #(
   parameter int WIDTH     = timer_input_pkg::PRESC_W,
   parameter int SHIFT_LO  = timer_input_pkg::PRE_SHIFT_LO,
   parameter int SHIFT_MID = timer_input_pkg::PRE_SHIFT_MID,
   parameter int SHIFT_HI  = timer_input_pkg::PRE_SHIFT_HI
) (
   input  wire logic                      clk,     // peripheral clock
   input  wire logic                      rst_n,   // async reset, active low
   input  wire timer_input_pkg::clk_sel_t sel,     // selected division
   output logic                           tick     // one-cycle enable
);
   import timer_input_pkg::*;

   typedef struct packed {
      logic [WIDTH-1:0] cnt;
      logic             tick;
   } presc_st_t;

   presc_st_t q;
   presc_st_t d;
   logic [WIDTH-1:0] mask;

   always_comb begin
      d = q;
      case (sel)
         CLK_DIV_MID: mask = WIDTH'((1 << SHIFT_MID) - 1);
         CLK_DIV_HI:  mask = WIDTH'((1 << SHIFT_HI) - 1);
         default:     mask = WIDTH'((1 << SHIFT_LO) - 1);
      endcase
      d.cnt  = q.cnt + WIDTH'(1);
      d.tick = ((q.cnt & mask) == mask);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign tick = q.tick;

endmodule

// ===== rtl/timer_edge_filter.sv
// Sampled noise filter and valid-edge detector for one timer input pin
`timescale 1ns/1ps
module timer_edge_filter (
   input  wire logic                       clk,        // peripheral clock
   input  wire logic                       rst_n,      // async reset, active low
   input  wire logic                       sample_en,  // noise filter sample strobe
   input  wire logic                       enable,     // counter running
   input  wire timer_input_pkg::edge_sel_t sel,        // valid edge choice
   input  wire logic                       pin,        // pin level
   output logic                            valid_edge, // one-cycle pulse
   output logic                            level       // sampled pin level
);
   import timer_input_pkg::*;

   typedef struct packed {
      logic s1;
      logic s2;
      logic ref_lvl;
      logic edge_q;
   } filt_st_t;

   filt_st_t q;
   filt_st_t d;

   always_comb begin
      d = q;
      d.edge_q = 1'b0;
      if (sample_en) begin
         d.s1 = pin;
         d.s2 = q.s1;
      end
      // Reference level holds while stopped, so a change made then is seen on enable
      if (enable && (q.s1 == q.s2) && (q.s2 != q.ref_lvl)) begin
         d.ref_lvl = q.s2;
         case (sel)
            EDGE_RISE: d.edge_q = q.s2;
            EDGE_FALL: d.edge_q = ~q.s2;
            EDGE_BOTH: d.edge_q = 1'b1;
            default:   d.edge_q = 1'b0;
         endcase
      end
   end

   // Reference resets low: a high pin after reset gives a rising edge on enable
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign valid_edge = q.edge_q;
   assign level      = q.s2;

endmodule

// ===== rtl/timer_input_detect.sv
// Timer input stage: AHB-Lite registers, edge filters, count clock selection and captures
//
// Overview of operation
// - High after reset gives rising edge on enable
// - High-stop, low-restart gives falling edge
// - Low-stop, high-restart gives rising edge
// - Input a sampled fast when count clock
// - Two equal samples needed before capture
// - Shared pin is input b or output
// - Event count read from count register
//
// The AHB-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module timer_input_detect #(
   parameter int COUNT_WIDTH = timer_input_pkg::COUNT_W
) (
   input  wire logic        hclk,               // peripheral clock
   input  wire logic        hresetn,            // async reset, active low
   input  wire logic        hsel,               // slave select
   input  wire logic [31:0] haddr,              // byte address
   input  wire logic [1:0]  htrans,             // transfer type
   input  wire logic        hwrite,             // write when high
   input  wire logic [2:0]  hsize,              // transfer size
   input  wire logic [31:0] hwdata,             // write data
   input  wire logic        hready,             // bus ready
   output logic             hreadyout,          // slave ready
   output logic             hresp,              // always OKAY
   output logic [31:0]      hrdata,             // read data
   input  wire logic        capture_input_a,    // first capture input pin
   input  wire logic        shared_port_pin_in, // shared pin level
   output logic             shared_port_pin_out,// timer output level
   output logic             shared_port_pin_oe  // high while driving shared pin
);
   import timer_input_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      bus_state_t              bus;
      logic [7:0]              addr;
      logic                    wr;
      logic                    ready;
      logic [31:0]             rdata;
      ctrl_t                   ctrl;
      clk_sel_t                psel;
      edge_cfg_t               edges;
      logic [COUNT_WIDTH-1:0]  count;
      logic [COUNT_WIDTH-1:0]  cap_a;
      logic [COUNT_WIDTH-1:0]  cap_b;
      logic                    flag_a;
      logic                    flag_b;
      logic                    ovr_a;
      logic                    ovr_b;
      logic                    pin_out;
      logic                    pin_oe;
   } top_st_t;

   top_st_t q;
   top_st_t d;

   logic    tick;
   logic    edge_a;
   logic    edge_b;
   logic    level_a;
   logic    level_b;
   logic    pin_b_lvl;
   logic    ext_mode;
   logic    sample_a;
   logic    b_active;
   logic    count_en;
   logic    take_a;
   logic    take_b;
   logic    accept;
   logic    wr_hit;
   status_t status;

   ////////////////////////////////////////////////////////////////////////////
   // Count clock and input stages

   timer_prescaler u_presc (
      .clk   (hclk),
      .rst_n (hresetn),
      .sel   (q.psel),
      .tick  (tick)
   );

   assign ext_mode = (q.psel == CLK_EDGE_A);
   // Input a sampled every cycle as count clock, else at the prescaled rate
   assign sample_a = ext_mode ? 1'b1 : tick;
   // Input b only exists while the shared pin is not the timer output
   assign b_active = q.ctrl.run & ~q.ctrl.pin_is_output;
   // Input b holds its own level while driving, so the driven level is no edge later
   assign pin_b_lvl = q.pin_oe ? level_b : shared_port_pin_in;

   timer_edge_filter u_edge_a (
      .clk        (hclk),
      .rst_n      (hresetn),
      .sample_en  (sample_a),
      .enable     (q.ctrl.run),
      .sel        (q.edges.a),
      .pin        (capture_input_a),
      .valid_edge (edge_a),
      .level      (level_a)
   );

   timer_edge_filter u_edge_b (
      .clk        (hclk),
      .rst_n      (hresetn),
      .sample_en  (tick),
      .enable     (b_active),
      .sel        (q.edges.b),
      .pin        (pin_b_lvl),
      .valid_edge (edge_b),
      .level      (level_b)
   );

   // Events counted from input a, otherwise from the prescaled clock
   assign count_en = q.ctrl.run & (ext_mode ? edge_a : tick);
   // No capture on input a while its edge drives the count
   assign take_a   = q.ctrl.cap_a_en & ~ext_mode & edge_a;
   assign take_b   = q.ctrl.cap_b_en & b_active & edge_b;

   assign status = '{level_b: level_b,
                     level_a: level_a,
                     ovr_b:   q.ovr_b,
                     ovr_a:   q.ovr_a,
                     cap_b:   q.flag_b,
                     cap_a:   q.flag_a};

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode

   assign accept = hsel & hready & htrans[1];
   assign wr_hit = (q.bus == BUS_DATA) & q.wr;

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      d = q;

      // Counter: cleared while stopped
      if (!q.ctrl.run) begin
         d.count = '0;
      end else if (count_en) begin
         d.count = q.count + COUNT_WIDTH'(1);
      end

      // Captures
      if (take_a) begin
         d.cap_a = q.count;
      end
      if (take_b) begin
         d.cap_b = q.count;
      end

      // Bus access
      case (q.bus)
         BUS_IDLE: begin
            d.ready = 1'b1;
            if (accept) begin
               d.addr  = haddr[7:0];
               d.wr    = hwrite;
               d.ready = 1'b0;
               d.bus   = BUS_DATA;
            end
         end
         BUS_DATA: begin
            d.ready = 1'b1;
            d.bus   = BUS_IDLE;
            d.rdata = '0;
            if (q.wr) begin
               case (q.addr)
                  OFF_CTRL: begin
                     d.ctrl = ctrl_t'(hwdata[CTRL_W-1:0]);
                  end
                  OFF_PRESCALE: begin
                     // Change of count clock refused while counting
                     if (!q.ctrl.run) begin
                        d.psel = clk_sel_t'(hwdata[PSEL_W-1:0]);
                     end
                  end
                  OFF_EDGE: begin
                     d.edges = edge_cfg_t'(hwdata[EDGE_W-1:0]);
                  end
                  default: begin
                  end
               endcase
            end else begin
               case (q.addr)
                  OFF_CTRL:     d.rdata = 32'(q.ctrl);
                  OFF_PRESCALE: d.rdata = 32'(q.psel);
                  OFF_EDGE:     d.rdata = 32'(q.edges);
                  OFF_STATUS:   d.rdata = 32'(status);
                  OFF_COUNT:    d.rdata = 32'(q.count);
                  OFF_CAP_A:    d.rdata = 32'(q.cap_a);
                  OFF_CAP_B:    d.rdata = 32'(q.cap_b);
                  default:      d.rdata = '0;
               endcase
            end
         end
         default: begin
            d.bus   = BUS_IDLE;
            d.ready = 1'b1;
         end
      endcase

      // Sticky flags: write one clears, a new capture in the same cycle wins
      if (wr_hit && (q.addr == OFF_STATUS)) begin
         d.flag_a = q.flag_a & ~hwdata[STS_CAP_A];
         d.flag_b = q.flag_b & ~hwdata[STS_CAP_B];
         d.ovr_a  = q.ovr_a & ~hwdata[STS_OVR_A];
         d.ovr_b  = q.ovr_b & ~hwdata[STS_OVR_B];
      end
      if (take_a) begin
         d.flag_a = 1'b1;
         d.ovr_a  = d.ovr_a | q.flag_a;
      end
      if (take_b) begin
         d.flag_b = 1'b1;
         d.ovr_b  = d.ovr_b | q.flag_b;
      end

      // Shared pin drives only in timer output function
      d.pin_oe  = d.ctrl.pin_is_output;
      d.pin_out = d.ctrl.pin_is_output & d.ctrl.out_level;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q        <= '0;
         q.bus    <= BUS_IDLE;
         q.ready  <= 1'b1;
         q.ctrl   <= CTRL_RST;
         q.psel   <= PRESCALE_RST;
         q.edges  <= EDGE_RST;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign hreadyout           = q.ready;
   assign hresp               = 1'b0;
   assign hrdata              = q.rdata;
   assign shared_port_pin_out = q.pin_out;
   assign shared_port_pin_oe  = q.pin_oe;

endmodule

// ===== tb/timer_input_monitor.sv
// Port checker for the timer input block: bus handshake and shared pin
`timescale 1ns/1ps
module timer_input_monitor #(
   parameter int COUNT_WIDTH = 16
) (
   input wire logic        hclk,                // clock
   input wire logic        hresetn,             // async reset, active low
   input wire logic        hsel,                // slave select
   input wire logic [1:0]  htrans,              // transfer type
   input wire logic        hwrite,              // write when high
   input wire logic        hready,              // bus ready
   input wire logic        hreadyout,           // slave ready
   input wire logic        hresp,               // response
   input wire logic [31:0] hrdata,              // read data
   input wire logic        shared_port_pin_out, // timer output level
   input wire logic        shared_port_pin_oe   // shared pin enable
);
   logic taken;
   logic wr_q;
   assign taken = hsel && hready && htrans[1];
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= 1'b0;
      end else if (taken) begin
         wr_q <= hwrite;
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   ////////////////////////////////////////////////////////////////////////////
   property p_okay; hresp == 1'b0; endproperty
   a_okay: assert property (p_okay) else $error("bus response not okay");
   property p_wait; taken |=> !hreadyout ##1 hreadyout; endproperty
   a_wait: assert property (p_wait) else $error("data phase length wrong");
   property p_cause; $fell(hreadyout) |-> $past(taken); endproperty
   a_cause: assert property (p_cause) else $error("wait state without transfer");
   property p_hold; hreadyout && $past(hreadyout) |-> $stable(hrdata); endproperty
   a_hold: assert property (p_hold) else $error("read data moved while idle");
   property p_wr_zero; $rose(hreadyout) && wr_q |-> hrdata == 32'h0; endproperty
   a_wr_zero: assert property (p_wr_zero) else $error("read data not cleared by write");
   property p_out_off; !shared_port_pin_oe |-> !shared_port_pin_out; endproperty
   a_out_off: assert property (p_out_off) else $error("output level while input");
   property p_oe_cause; $changed(shared_port_pin_oe) |-> $rose(hreadyout) && wr_q; endproperty
   a_oe_cause: assert property (p_oe_cause) else $error("pin enable moved without write");
   property p_out_cause; $changed(shared_port_pin_out) |-> $rose(hreadyout) && wr_q; endproperty
   a_out_cause: assert property (p_out_cause) else $error("pin level moved without write");
endmodule

bind timer_input_detect timer_input_monitor #(.COUNT_WIDTH(COUNT_WIDTH)) mon (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .shared_port_pin_out(shared_port_pin_out), .shared_port_pin_oe(shared_port_pin_oe));

// ===== tb/pin_source.sv
// External signal sources for the two timer input pins
`timescale 1ns/1ps
module pin_source (
   input  wire logic clk,   // peripheral clock
   output logic      pin_a, // first capture input level
   output logic      pin_b  // shared pin drive while released by the block
);
   initial begin
      pin_a = 1'b1;
      pin_b = 1'b0;
   end
   // Caller keeps levels well beyond two count clocks except for glitch tests
   task automatic set_a(input logic v, input int n);
      pin_a <= v;
      repeat (n) @(posedge clk);
   endtask
   task automatic set_b(input logic v, input int n);
      pin_b <= v;
      repeat (n) @(posedge clk);
   endtask
endmodule

// ===== tb/tb.sv
// Self-checking bench for the timer input block
`timescale 1ns/1ps
module tb;
   import timer_input_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rdat;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        pin_a, pin_b, pin_out, pin_oe, shared_lvl;
   int          err_count, cmp_count, cyc;
   logic [7:0]  offs [6];
   assign shared_lvl = pin_oe ? pin_out : pin_b;

   timer_input_detect dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .capture_input_a(pin_a), .shared_port_pin_in(shared_lvl),
      .shared_port_pin_out(pin_out), .shared_port_pin_oe(pin_oe));
   pin_source src (.clk(hclk), .pin_a(pin_a), .pin_b(pin_b));

   ////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      if (err_count == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         $display("unexpected %s: expected %h seen %h", nm, exp, got);
         err_count++;
      end
   endtask
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
      haddr  <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'b10;
      hsel   <= 1'b1;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rdat = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp, input string nm);
      xfer(a, 1'b0, 32'h0);
      chk(nm, exp, rdat & m);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 3000) begin
         err_count++;
         test_done();
      end
   end
   initial begin
      {hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize = 3'h2;
      hresetn = 1'b0;
      err_count = 0;
      cmp_count = 0;
      cyc = 0;
      offs = '{OFF_CTRL, OFF_PRESCALE, OFF_EDGE, OFF_COUNT, OFF_CAP_A, OFF_CAP_B};
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      foreach (offs[i]) rdc(offs[i], 32'hffffffff, 32'h0, "reset value");
      rdc(OFF_STATUS, 32'hf, 32'h0, "status reset");
      wr(8'h1c, 32'hffffffff);
      rdc(8'h1c, 32'hffffffff, 32'h0, "unmapped");
      // Event counting on input a, high since reset
      wr(OFF_PRESCALE, 32'(CLK_EDGE_A));
      wr(OFF_EDGE, 32'(EDGE_BOTH));
      wr(OFF_CTRL, 32'h1);
      repeat (8) @(posedge hclk);
      rdc(OFF_COUNT, 32'hffffffff, 32'h1, "count after enable");
      src.set_a(1'b0, 1);
      src.set_a(1'b1, 8);
      rdc(OFF_COUNT, 32'hffffffff, 32'h1, "count after glitch");
      src.set_a(1'b0, 6);
      src.set_a(1'b1, 8);
      rdc(OFF_COUNT, 32'hffffffff, 32'h3, "count after pulse");
      wr(OFF_PRESCALE, 32'(CLK_DIV_LO));
      rdc(OFF_PRESCALE, 32'hffffffff, 32'(CLK_EDGE_A), "prescaler while running");
      // Level changes while stopped
      for (int i = 0; i < 2; i++) begin
         wr(OFF_CTRL, 32'h0);
         rdc(OFF_COUNT, 32'hffffffff, 32'h0, "count stopped");
         src.set_a(i[0], 6);
         wr(OFF_EDGE, 32'(i[0] ? EDGE_RISE : EDGE_FALL));
         wr(OFF_CTRL, 32'h1);
         repeat (8) @(posedge hclk);
         rdc(OFF_COUNT, 32'hffffffff, 32'h1, "count on restart");
      end
      // Captures and the shared pin
      wr(OFF_CTRL, 32'h0);
      wr(OFF_PRESCALE, 32'(CLK_DIV_LO));
      rdc(OFF_PRESCALE, 32'hffffffff, 32'(CLK_DIV_LO), "prescaler while stopped");
      wr(OFF_EDGE, 32'h5);
      wr(OFF_CTRL, 32'h1f);
      chk("pin enable", 32'h1, {31'h0, pin_oe});
      chk("pin level", 32'h1, {31'h0, pin_out});
      src.set_a(1'b0, 10);
      src.set_a(1'b1, 20);
      src.set_b(1'b1, 20);
      src.set_b(1'b0, 4);
      rdc(OFF_STATUS, 32'h13, 32'h11, "status with pin output");
      wr(OFF_STATUS, 32'h3);
      wr(OFF_CTRL, 32'h07);
      chk("pin enable", 32'h0, {31'h0, pin_oe});
      chk("pin level", 32'h0, {31'h0, pin_out});
      repeat (8) @(posedge hclk);
      rdc(OFF_STATUS, 32'h3, 32'h0, "status after pin release");
      src.set_b(1'b1, 20);
      rdc(OFF_STATUS, 32'h3, 32'h2, "status with pin input");
      test_done();
   end
endmodule
